// ---- rtl/amc_mode_cal_ctrl.sv ----
// Mode decoding, calibration sequencing and serial register access of the ADC
//
// Overview of operation
// - Control word is 24 bits: mode, gain, channel, flags, then 12-bit filter code.
// - In normal mode a read with register_select high returns the data register.
// - Reset puts mode_select back to normal mode.
// - Mode 001 self-calibrates the selected channel, then clears mode to normal.
// - End of self-calibration drives data_ready_n low; the data register keeps its last published word.
// - Self-calibration takes zero from shorted inputs, full scale from the reference.
// - Mode 010 calibrates system zero on the channel, flags ready, returns normal.
// - Mode 011 calibrates system full scale on the channel, flags ready, returns normal.
// - Mode 100 takes zero from channel, full scale from reference, flags, returns normal.
// - Mode 101 interleaves zero and reference steps, words arrive six times less often.
// - Background mode updates coefficients by itself from zero and reference measurements.
// - Mode 110 maps register_select high transfers onto the zero-scale coefficient.
// - Mode 111 maps register_select high transfers onto the full-scale coefficient.
// - Coefficient transfers are always 24 bits regardless of word_length_bit.
// - Coefficient writes shorter than 24 bits are dropped and change nothing.
// - Control writes act only after 24 bits; further clocks in the frame are ignored.
// - data_ready_n falls on a new word and rises after a full word is read.
`timescale 1ns/1ps
module amc_mode_cal_ctrl
  import amc_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst,
  input  wire logic      sclk,
  input  wire logic      tfs_n,
  input  wire logic      rfs_n,
  input  wire logic      register_select,
  input  wire logic      sdata_in,
  output logic           sdata_out,
  output logic           sdata_oe,
  output logic           data_ready_n,
  input  wire amc_meas_s meas,
  output amc_ctrl_s      ctrl,
  output amc_fe_e        front_end
);

  // Link domain state
  logic        wr_clr;
  logic        rd_clr;
  logic [4:0]  wr_cnt;
  logic [22:0] wr_shift;
  logic [23:0] wr_hold;
  logic        wr_hold_sel;
  logic        wr_tgl;
  logic [4:0]  rd_cnt;
  logic        rd_tgl;

  // Core domain state
  logic        wr_s1, wr_s2, wr_seen;
  logic        rd_s1, rd_s2, rd_seen;
  logic        rfs_s1, rfs_s2, rfs_prev;
  logic        sel_s1, sel_s2;
  logic [23:0] rd_word;
  logic [4:0]  rd_len;
  logic        rd_is_data;
  logic [23:0] data_reg;
  logic [23:0] zero_coef [2];
  logic [23:0] full_coef [2];
  amc_seq_e    seq;
  logic [2:0]  bg_cnt;
  logic [2:0]  meas_cnt;

  // Decoded events
  logic        wr_evt, wr_ctrl, wr_coef, rd_evt, rd_start, meas_ok;
  logic        seq_done, publish;
  amc_seq_e    start_seq;
  amc_fe_e     next_front_end;

  assign wr_clr   = rst | tfs_n;
  assign rd_clr   = rst | rfs_n;
  assign wr_evt   = wr_s2 ^ wr_seen;
  assign wr_ctrl  = wr_evt & ~wr_hold_sel;
  assign wr_coef  = wr_evt & wr_hold_sel;
  assign rd_evt   = rd_s2 ^ rd_seen;
  assign rd_start = rfs_prev & ~rfs_s2;
  assign meas_ok  = meas.valid & ~ctrl.power_down_bit;

  // Write shifter: counts only the first 24 clocks of a transmit frame
  always_ff @(posedge sclk or posedge wr_clr) begin
    if (wr_clr) begin
      wr_cnt   <= 5'h00;
      wr_shift <= 23'h000000;
    end else if (wr_cnt < LEN_FULL) begin
      wr_cnt   <= wr_cnt + 5'h01;
      wr_shift <= {wr_shift[21:0], sdata_in};
    end
  end

  // Full word hand-off; short frames never reach this and are dropped
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr_hold     <= CTRL_RESET;
      wr_hold_sel <= 1'b0;
      wr_tgl      <= 1'b0;
    end else if (!tfs_n && wr_cnt == LAST_WR_BIT) begin
      wr_hold     <= {wr_shift, sdata_in};
      wr_hold_sel <= register_select;
      wr_tgl      <= ~wr_tgl;
    end
  end

  // Read shifter: presents bits on falling sclk, MSB first
  always_ff @(negedge sclk or posedge rd_clr) begin
    if (rd_clr) begin
      rd_cnt    <= 5'h00;
      sdata_out <= 1'b0;
    end else if (rd_cnt < rd_len) begin
      rd_cnt    <= rd_cnt + 5'h01;
      sdata_out <= rd_word[5'(WORD_BITS - 1) - rd_cnt];
    end else begin
      sdata_out <= 1'b0;
    end
  end

  // Completion toggle for a read
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rd_tgl <= 1'b0;
    end else if (!rfs_n && rd_cnt == rd_len - 5'h01) begin
      rd_tgl <= ~rd_tgl;
    end
  end

  // Synchronisers into the core clock
  always_ff @(posedge clock) begin
    wr_s1  <= wr_tgl;
    wr_s2  <= wr_s1;
    rd_s1  <= rd_tgl;
    rd_s2  <= rd_s1;
    rfs_s1 <= rfs_n;
    rfs_s2 <= rfs_s1;
    sel_s1 <= register_select;
    sel_s2 <= sel_s1;
  end

  // Edge detectors behind the synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_seen  <= wr_s2;
      rd_seen  <= rd_s2;
      rfs_prev <= 1'b1;
    end else begin
      wr_seen  <= wr_s2;
      rd_seen  <= rd_s2;
      rfs_prev <= rfs_s2;
    end
  end

  // Data pin drive while a receive frame is open
  always_ff @(posedge clock) begin
    if (rst) begin
      sdata_oe <= 1'b0;
    end else begin
      sdata_oe <= ~rfs_s2;
    end
  end

  // Read source chosen at frame start and held for the frame
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_word    <= DATA_RESET;
      rd_len     <= LEN_FULL;
      rd_is_data <= 1'b0;
    end else if (rd_start) begin
      rd_is_data <= 1'b0;
      rd_len     <= LEN_FULL;
      if (!sel_s2) begin
        rd_word <= ctrl;
      end else if (ctrl.mode_select == MODE_RW_ZERO) begin
        rd_word <= zero_coef[ctrl.channel_select];
      end else if (ctrl.mode_select == MODE_RW_FULL) begin
        rd_word <= full_coef[ctrl.channel_select];
      end else begin
        rd_word    <= data_reg;
        rd_is_data <= 1'b1;
        rd_len     <= ctrl.word_length_bit ? LEN_FULL : LEN_SHORT;
      end
    end
  end

  // First sequencer step for each mode
  always_comb begin
    case (wr_hold[23:21])
      MODE_SELF_CAL, MODE_SYS_ZERO, MODE_SYS_OFFS, MODE_BACKGND: start_seq = SEQ_ZERO;
      MODE_SYS_FULL: start_seq = SEQ_FULL;
      default:       start_seq = SEQ_CONV;
    endcase
  end

  // Calibration end: last step of a one-shot mode measured
  always_comb begin
    seq_done = 1'b0;
    if (meas_ok && !wr_ctrl) begin
      case (seq)
        SEQ_ZERO: seq_done = ctrl.mode_select == MODE_SYS_ZERO;
        SEQ_FULL: seq_done = ctrl.mode_select != MODE_BACKGND;
        default:  seq_done = 1'b0;
      endcase
    end
  end

  // New output word: plain conversion, or last one of a background round
  assign publish = meas_ok && !wr_ctrl && seq == SEQ_CONV &&
                   (ctrl.mode_select != MODE_BACKGND || bg_cnt == BG_CONV_MEAS - 3'h1);

  // Control register; a host write wins over the automatic return to normal
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= wr_hold;
    end else if (seq_done) begin
      ctrl.mode_select <= MODE_NORMAL;
    end
  end

  // Measurement sequencer; restarts on every control write
  always_ff @(posedge clock) begin
    if (rst) begin
      seq    <= SEQ_CONV;
      bg_cnt <= 3'h0;
    end else if (wr_ctrl) begin
      seq    <= start_seq;
      bg_cnt <= 3'h0;
    end else if (meas_ok) begin
      case (seq)
        SEQ_ZERO: begin
          if (ctrl.mode_select == MODE_SYS_ZERO) begin
            seq <= SEQ_CONV;
          end else begin
            seq <= SEQ_FULL;
          end
        end
        SEQ_FULL: begin
          seq    <= SEQ_CONV;
          bg_cnt <= 3'h0;
        end
        default: begin
          if (ctrl.mode_select == MODE_BACKGND) begin
            if (bg_cnt == BG_CONV_MEAS - 3'h1) begin
              seq <= SEQ_ZERO;
            end else begin
              bg_cnt <= bg_cnt + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Front-end input for the step being measured
  always_comb begin
    case (seq)
      SEQ_ZERO: begin
        next_front_end = (ctrl.mode_select == MODE_SELF_CAL ||
                          ctrl.mode_select == MODE_BACKGND) ? FE_SHORT : FE_CHAN;
      end
      SEQ_FULL: begin
        next_front_end = (ctrl.mode_select == MODE_SYS_FULL) ? FE_CHAN : FE_REF;
      end
      default: next_front_end = FE_CHAN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      front_end <= FE_CHAN;
    end else begin
      front_end <= next_front_end;
    end
  end

  // Conversion data register
  always_ff @(posedge clock) begin
    if (rst) begin
      data_reg <= DATA_RESET;
    end else if (publish) begin
      data_reg <= meas.value;
    end
  end

  // Per-channel coefficients: host writes in the access modes, sequencer otherwise
  for (genvar ch = 0; ch < 2; ch++) begin : g_coef
    always_ff @(posedge clock) begin
      if (rst) begin
        zero_coef[ch] <= COEF_RESET;
        full_coef[ch] <= COEF_RESET;
      end else if (ctrl.channel_select == 1'(ch)) begin
        if (wr_coef && ctrl.mode_select == MODE_RW_ZERO) begin
          zero_coef[ch] <= wr_hold;
        end else if (wr_coef && ctrl.mode_select == MODE_RW_FULL) begin
          full_coef[ch] <= wr_hold;
        end else if (meas_ok && !wr_ctrl && seq == SEQ_ZERO) begin
          zero_coef[ch] <= meas.value;
        end else if (meas_ok && !wr_ctrl && seq == SEQ_FULL) begin
          full_coef[ch] <= meas.value;
        end
      end
    end
  end

  // Ready flag: a new word pulls it low, a finished data read releases it
  always_ff @(posedge clock) begin
    if (rst) begin
      data_ready_n <= 1'b1;
    end else if (publish || seq_done) begin
      data_ready_n <= 1'b0;
    end else if (rd_evt && rd_is_data) begin
      data_ready_n <= 1'b1;
    end
  end

  // Helper: measurements taken since the last word or control write
  always_ff @(posedge clock) begin
    if (rst || wr_ctrl || publish) begin
      meas_cnt <= 3'h0;
    end else if (meas_ok && meas_cnt != 3'h7) begin
      meas_cnt <= meas_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_cal_end;
    seq_done ##1 (ctrl.mode_select == MODE_NORMAL);
  endsequence

  property p_reset_normal;
    @(posedge clock) disable iff (1'b0) rst |=> ctrl.mode_select == MODE_NORMAL;
  endproperty

  a_reset_mode_normal: assert property (p_reset_normal)
    else $error("mode not normal after reset");
  a_ctrl_write_load: assert property (wr_ctrl |=> ctrl == $past(wr_hold))
    else $error("control write not loaded");
  a_cal_end_normal: assert property (seq_done |-> s_cal_end)
    else $error("mode did not return to normal");
  a_cal_end_ready: assert property (seq_done |=> !data_ready_n)
    else $error("calibration end not flagged");
  a_self_zero_short: assert property (
    (seq == SEQ_ZERO && ctrl.mode_select == MODE_SELF_CAL)[*2] |-> front_end == FE_SHORT)
    else $error("self zero not on shorted input");
  a_sys_zero_chan: assert property (
    (seq == SEQ_ZERO && ctrl.mode_select == MODE_SYS_ZERO)[*2] |-> front_end == FE_CHAN)
    else $error("system zero not on channel");
  a_sys_full_chan: assert property (
    (seq == SEQ_FULL && ctrl.mode_select == MODE_SYS_FULL)[*2] |-> front_end == FE_CHAN)
    else $error("system full not on channel");
  a_offs_full_ref: assert property (
    (seq == SEQ_FULL && ctrl.mode_select == MODE_SYS_OFFS)[*2] |-> front_end == FE_REF)
    else $error("offset full scale not on reference");
  a_bg_word_rate: assert property (
    publish && ctrl.mode_select == MODE_BACKGND |-> meas_cnt == BG_WORD_MEAS - 3'h1)
    else $error("background word rate wrong");
  a_bg_zero_update: assert property (
    meas_ok && !wr_ctrl && seq == SEQ_ZERO && ctrl.mode_select == MODE_BACKGND
    |=> zero_coef[ctrl.channel_select] == $past(meas.value))
    else $error("background zero not stored");
  a_zero_coef_write: assert property (
    wr_coef && ctrl.mode_select == MODE_RW_ZERO
    |=> zero_coef[ctrl.channel_select] == $past(wr_hold))
    else $error("zero coefficient not written");
  a_full_coef_write: assert property (
    wr_coef && ctrl.mode_select == MODE_RW_FULL
    |=> full_coef[ctrl.channel_select] == $past(wr_hold))
    else $error("full coefficient not written");
  a_coef_read_len: assert property (
    rd_start && sel_s2 && ctrl.mode_select[2:1] == 2'b11 |=> rd_len == LEN_FULL)
    else $error("coefficient read not 24 bits");
  a_data_read_src: assert property (
    rd_start && sel_s2 && ctrl.mode_select == MODE_NORMAL |=> rd_word == $past(data_reg))
    else $error("normal read not from data register");
  a_ready_release: assert property (
    rd_evt && rd_is_data && !publish && !seq_done |=> data_ready_n)
    else $error("ready not released after read");
  a_full_word_only: assert property (
    @(posedge sclk) disable iff (wr_clr) $changed(wr_tgl) |-> $past(wr_cnt) == LAST_WR_BIT)
    else $error("short write handed off");

endmodule

// ---- rtl/amc_pkg.sv ----
// Package for the ADC mode and calibration control block
package amc_pkg;

  // Word sizes on the serial port
  localparam int unsigned WORD_BITS    = 24;
  localparam int unsigned SHORT_BITS   = 16;
  localparam logic [4:0]  LEN_FULL     = 5'h18;
  localparam logic [4:0]  LEN_SHORT    = 5'h10;
  localparam logic [4:0]  LAST_WR_BIT  = 5'h17;

  // Background mode: conversions per word besides the zero and full steps, and all measurements per word
  localparam logic [2:0]  BG_CONV_MEAS = 3'h4;
  localparam logic [2:0]  BG_WORD_MEAS = 3'h6;

  // Reset values
  localparam logic [23:0] CTRL_RESET   = 24'h000000;
  localparam logic [23:0] COEF_RESET   = 24'h000000;
  localparam logic [23:0] DATA_RESET   = 24'h000000;

  // Operating modes held in mode_select
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_SELF_CAL = 3'b001,
    MODE_SYS_ZERO = 3'b010,
    MODE_SYS_FULL = 3'b011,
    MODE_SYS_OFFS = 3'b100,
    MODE_BACKGND  = 3'b101,
    MODE_RW_ZERO  = 3'b110,
    MODE_RW_FULL  = 3'b111
  } amc_mode_e;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    SEQ_CONV = 2'b00,
    SEQ_ZERO = 2'b01,
    SEQ_FULL = 2'b10
  } amc_seq_e;

  // Analog front-end input selection
  typedef enum logic [1:0] {
    FE_CHAN  = 2'b00,
    FE_SHORT = 2'b01,
    FE_REF   = 2'b10
  } amc_fe_e;

  // Control word, most significant field first
  typedef struct packed {
    amc_mode_e   mode_select;
    logic [2:0]  gain_select;
    logic        channel_select;
    logic        power_down_bit;
    logic        word_length_bit;
    logic        excitation_bit;
    logic        burnout_bit;
    logic        polarity_select;
    logic [11:0] filter_code;
  } amc_ctrl_s;

  // Measurement from the modulator and filter
  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } amc_meas_s;

endpackage

// ---- sim/amc_host_model.sv ----
// Host microcontroller model on the framed serial port
`timescale 1ns/1ps
module amc_host_model (
  output logic      sclk,
  output logic      tfs_n,
  output logic      rfs_n,
  output logic      register_select,
  output logic      sdata_in,
  input  wire logic sdata_out
);
  // Idle levels: clock high and still, both frames inactive
  initial begin
    sclk = 1'b1;
    tfs_n = 1'b1;
    rfs_n = 1'b1;
    register_select = 1'b0;
    sdata_in = 1'b0;
  end

  // Send the low n bits of d, MSB first, data set up before each rising sclk
  task automatic write_word(input logic rs, input logic [27:0] d, input int n);
    register_select = rs;
    tfs_n = 1'b0;
    #10;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      sdata_in = d[i];
      #7.5;
      sclk = 1'b1;
      #7.5;
    end
    tfs_n = 1'b1;
    sdata_in = ~sdata_in; // Released line shows no stale bit
    #100; // Gap between word completions
  endtask

  // Clock n bits out of the device, sampled on rising sclk
  task automatic read_word(input logic rs, input int n, output logic [23:0] d);
    register_select = rs;
    rfs_n = 1'b0;
    #100; // Device snapshots the source first
    d = '0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      #7.5;
      sclk = 1'b1;
      d = {d[22:0], sdata_out};
      #7.5;
    end
    rfs_n = 1'b1;
    #60;
  endtask
endmodule

// ---- sim/amc_mode_cal_ctrl_tb.sv ----
// Self-checking testbench of the ADC mode and calibration control block
`timescale 1ns/1ps
module amc_mode_cal_ctrl_tb;
  import amc_pkg::*;
  logic        clock;
  logic        rst;
  logic        sclk;
  logic        tfs_n;
  logic        rfs_n;
  logic        register_select;
  logic        sdata_in;
  logic        sdata_out;
  logic        sdata_oe;
  logic        data_ready_n;
  amc_meas_s   meas;
  amc_ctrl_s   ctrl;
  amc_fe_e     front_end;
  logic [23:0] rd;
  logic [23:0] bg [6];
  int          miscompares;
  int          n_checks;

  amc_mode_cal_ctrl amc_mode_cal_ctrl_inst (.clock(clock), .rst(rst), .sclk(sclk),
    .tfs_n(tfs_n), .rfs_n(rfs_n), .register_select(register_select), .sdata_in(sdata_in),
    .sdata_out(sdata_out), .sdata_oe(sdata_oe), .data_ready_n(data_ready_n), .meas(meas),
    .ctrl(ctrl), .front_end(front_end));
  amc_host_model amc_host_model_inst (.sclk(sclk), .tfs_n(tfs_n), .rfs_n(rfs_n),
    .register_select(register_select), .sdata_in(sdata_in), .sdata_out(sdata_out));

  // Core clock, 20 ns
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare and count
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] e);
    n_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One filter result, valid for a single cycle
  task automatic pulse(input logic [23:0] v);
    meas = {1'b1, v};
    cyc(1);
    meas.valid = 1'b0;
    cyc(4);
  endtask

  // Control word, 16-bit data words, filter top bit kept at zero
  function automatic logic [23:0] cw(input logic [2:0] md, input logic ch);
    return {md, 3'h2, ch, 5'h00, 12'h013};
  endfunction

  task automatic wctl(input logic [23:0] w);
    amc_host_model_inst.write_word(1'b0, {4'h0, w}, 24);
    cyc(8);
  endtask

  // Read one word; the data pin must be driven inside the frame and released after it
  task automatic rdchk(input string nm, input logic rs, input int n, input logic [23:0] e);
    fork
      amc_host_model_inst.read_word(rs, n, rd);
      begin
        cyc(4);
        check("oe in frame", sdata_oe, 1'b1);
      end
    join
    cyc(8);
    check(nm, rd, e);
    check("oe after frame", sdata_oe, 1'b0);
  endtask

  // Both coefficients of one channel, always 24-bit words
  task automatic coef(input logic ch, input logic [23:0] z, input logic [23:0] f);
    wctl(cw(3'b110, ch));
    rdchk("zero coef", 1'b1, 24, z);
    wctl(cw(3'b111, ch));
    rdchk("full coef", 1'b1, 24, f);
  endtask

  // One calibration run, then a data read that clears ready
  task automatic cal(input logic [2:0] md, input logic ch, input amc_fe_e fa,
                     input logic [23:0] va, input logic two, input amc_fe_e fb,
                     input logic [23:0] vb);
    wctl(cw(md, ch));
    check("front end a", front_end, fa);
    pulse(va);
    if (two) begin
      check("front end b", front_end, fb);
      pulse(vb);
    end
    check("mode back", ctrl.mode_select, MODE_NORMAL);
    check("cal ready", data_ready_n, 1'b0);
    amc_host_model_inst.read_word(1'b1, 16, rd);
    cyc(8);
    check("ready cleared", data_ready_n, 1'b1);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1000000;
    miscompares++;
    complete_run;
  end

  // Main sequence
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst = 1'b1;
    meas = '0;
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    cyc(4);
    check("reset ctrl", ctrl, CTRL_RESET);
    check("reset ready", data_ready_n, 1'b1);
    check("reset front end", front_end, FE_CHAN);
    check("reset oe", sdata_oe, 1'b0);
    rdchk("ctrl read", 1'b0, 24, CTRL_RESET);
    // Field layout, extra clocks and short words
    wctl(24'h1A8123);
    check("ctrl word", ctrl, 24'h1A8123);
    rdchk("ctrl read", 1'b0, 24, 24'h1A8123);
    amc_host_model_inst.write_word(1'b0, {24'h0E8456, 4'hF}, 28);
    cyc(8);
    check("ctrl extra clocks", ctrl, 24'h0E8456);
    amc_host_model_inst.write_word(1'b0, 28'h0000FFF, 12);
    cyc(8);
    check("ctrl short", ctrl, 24'h0E8456);
    // Power-down drops results; word_length_bit set gives 24-bit data words
    wctl(cw(3'b000, 1'b0) | 24'h010000);
    pulse(24'h111111);
    check("pd no word", data_ready_n, 1'b1);
    wctl(cw(3'b000, 1'b0) | 24'h008000);
    pulse(24'h13579B);
    rdchk("data read 24", 1'b1, 24, 24'h13579B);
    // Normal conversion
    wctl(cw(3'b000, 1'b0));
    pulse(24'hABCDEF);
    check("new word", data_ready_n, 1'b0);
    rdchk("data read", 1'b1, 16, 24'h00ABCD);
    check("word read", data_ready_n, 1'b1);
    // Calibration modes
    cal(3'b001, 1'b0, FE_SHORT, 24'h000111, 1'b1, FE_REF, 24'hFFF222);
    cal(3'b010, 1'b1, FE_CHAN, 24'h000333, 1'b0, FE_CHAN, 24'h0);
    cal(3'b011, 1'b1, FE_CHAN, 24'hEEE444, 1'b0, FE_CHAN, 24'h0);
    cal(3'b100, 1'b0, FE_CHAN, 24'h000555, 1'b1, FE_REF, 24'hDDD666);
    coef(1'b0, 24'h000555, 24'hDDD666);
    coef(1'b1, 24'h000333, 24'hEEE444);
    // Coefficient write, then a short one that must be dropped
    wctl(cw(3'b110, 1'b1));
    amc_host_model_inst.write_word(1'b1, 28'h0123456, 24);
    amc_host_model_inst.write_word(1'b1, 28'h000FFFF, 16);
    rdchk("coef write", 1'b1, 24, 24'h123456);
    // Background calibration: six measurements per word
    bg = '{24'h000777, 24'hCCC888, 24'h111111, 24'h222222, 24'h333333, 24'h444444};
    wctl(cw(3'b101, 1'b0));
    check("bg front end", front_end, FE_SHORT);
    for (int i = 0; i < 6; i++) begin
      pulse(bg[i]);
      check("bg ready", data_ready_n, (i < 5) ? 1'b1 : 1'b0);
    end
    rdchk("bg data", 1'b1, 16, 24'h004444);
    coef(1'b0, 24'h000777, 24'hCCC888);
    // Abandon a self-calibration after its zero step
    wctl(cw(3'b001, 1'b1));
    pulse(24'h0000AA);
    wctl(cw(3'b000, 1'b1));
    check("abandon front end", front_end, FE_CHAN);
    check("abandon ready", data_ready_n, 1'b1);
    coef(1'b1, 24'h0000AA, 24'hEEE444);
    // Reset in mid-run, with a pending word and background mode active
    wctl(cw(3'b000, 1'b0));
    pulse(24'h5A5A5A);
    wctl(cw(3'b101, 1'b1));
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(4);
    check("mid reset ctrl", ctrl, CTRL_RESET);
    check("mid reset ready", data_ready_n, 1'b1);
    check("mid reset front end", front_end, FE_CHAN);
    coef(1'b1, COEF_RESET, COEF_RESET);
    complete_run;
  end
endmodule
